// >>> src/ceu_cfg.svh
`ifndef CEU_CFG_SVH
`define CEU_CFG_SVH

// event register addresses in the control region
`define CEU_ADDR_TRAP 32'hff000020
`define CEU_ADDR_EXCEPTION_EVENT_CODE 32'hff000024
`define CEU_ADDR_INTERRUPT_EVENT_CODE 32'hff000028
// top 3 address bits ignored, so the alias region decodes too
`define CEU_ALIAS_MASK 32'he0000000

// reset values of the exception event register
`define CEU_EXP_POR 32'h00000000
`define CEU_EXP_MAN 32'h00000020

// fixed reset vector and offsets
`define CEU_RESET_VEC 32'ha0000000
`define CEU_OFS_GEN 32'h00000100
`define CEU_OFS_MISS 32'h00000400

// event codes
`define CEU_C_POR 12'h000
`define CEU_C_MAN 12'h020
`define CEU_C_MHIT 12'h140
`define CEU_C_IADE 12'h0e0
`define CEU_C_ITLBM 12'h040
`define CEU_C_IPROT 12'h0a0
`define CEU_C_ILL 12'h180
`define CEU_C_SILL 12'h1a0
`define CEU_C_FPUD 12'h800
`define CEU_C_SFPUD 12'h820
`define CEU_C_DADR 12'h0e0
`define CEU_C_DADW 12'h100
`define CEU_C_DTLBR 12'h040
`define CEU_C_DTLBW 12'h060
`define CEU_C_DPROTR 12'h0a0
`define CEU_C_DPROTW 12'h0c0
`define CEU_C_FPU 12'h120
`define CEU_C_IPW 12'h080
`define CEU_C_TRAP 12'h160
`define CEU_C_UBRK 12'h1e0

// status word bit positions
`define CEU_SR_MD 30
`define CEU_SR_RB 29
`define CEU_SR_BL 28
`define CEU_SR_FD 15

`endif

// >>> src/ceu_event_regs.sv
`timescale 1ns/1ps
`include "ceu_cfg.svh"

// three memory-mapped event registers with registered read data
module ceu_event_regs
    import ceu_pkg::*;
#(
    parameter int INT_W = 14
) (
    input wire logic clk_i, // core clock
    input wire logic rst_b_i, // async reset, active low
    input wire logic man_rst_i, // reset was a manual reset
    input wire logic [31:0] addr_i, // access address
    input wire logic rd_i, // read strobe
    input wire logic wr_i, // write strobe
    input wire logic [31:0] wdata_i, // write data
    input wire logic exp_ld_i, // hardware load of exception code
    input wire logic [11:0] exp_code_i, // exception code
    input wire logic int_ld_i, // hardware load of interrupt code
    input wire logic [INT_W-1:0] int_code_i, // interrupt code
    input wire logic trap_ld_i, // hardware load of trap immediate
    input wire logic [7:0] trap_imm_i, // trap immediate
    input wire logic rst_ld_i, // reset-class entry in progress
    output logic [31:0] rdata_o, // registered read data
    output logic hit_o // address matched a register
);
    logic [7:0] sw_call;
    logic [11:0] exp_code;
    logic [INT_W-1:0] int_code;
    logic sel_trap;
    logic sel_exp;
    logic sel_int;

    // decode with top address bits forced high
    assign sel_trap = ((addr_i | `CEU_ALIAS_MASK) == `CEU_ADDR_TRAP);
    assign sel_exp = ((addr_i | `CEU_ALIAS_MASK) == `CEU_ADDR_EXCEPTION_EVENT_CODE);
    assign sel_int = ((addr_i | `CEU_ALIAS_MASK) == `CEU_ADDR_INTERRUPT_EVENT_CODE);

    // trap code: hardware load wins over store
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            sw_call <= 8'h00;
        end
        else if (trap_ld_i)
        begin
            sw_call <= trap_imm_i;
        end
        else if (wr_i && sel_trap)
        begin
            sw_call <= wdata_i[9:2];
        end
    end

    // exception event code
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            exp_code <= 12'(`CEU_EXP_POR);
        end
        else if (rst_ld_i && man_rst_i)
        begin
            exp_code <= 12'(`CEU_EXP_MAN);
        end
        else if (exp_ld_i)
        begin
            exp_code <= exp_code_i;
        end
        else if (wr_i && sel_exp)
        begin
            exp_code <= wdata_i[11:0];
        end
    end

    // interrupt event code
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            int_code <= '0;
        end
        else if (int_ld_i)
        begin
            int_code <= int_code_i;
        end
        else if (wr_i && sel_int)
        begin
            int_code <= wdata_i[INT_W-1:0];
        end
    end

    // registered read data and hit flag
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            rdata_o <= 32'h00000000;
            hit_o <= 1'b0;
        end
        else
        begin
            hit_o <= (rd_i || wr_i) && (sel_trap || sel_exp || sel_int);
            if (rd_i && sel_trap)
            begin
                rdata_o <= {22'h000000, sw_call, 2'h0};
            end
            else if (rd_i && sel_exp)
            begin
                rdata_o <= {20'h00000, exp_code};
            end
            else if (rd_i && sel_int)
            begin
                rdata_o <= {{(32-INT_W){1'b0}}, int_code};
            end
            else
            begin
                rdata_o <= 32'h00000000;
            end
        end
    end
endmodule

// >>> src/ceu_pkg.sv
package ceu_pkg;
    typedef enum logic [2:0] {
        CEU_IDLE = 3'b001,
        CEU_ENTRY = 3'b010,
        CEU_RETURN = 3'b100
    } ceu_state_type;

    typedef enum logic [1:0] {
        CEU_VEC_RESET = 2'h0,
        CEU_VEC_BASE = 2'h1,
        CEU_VEC_DEBUG = 2'h2
    } ceu_vec_type;
endpackage

// >>> src/ceu_top.sv
// What this block does
// - save pc, status and stack on entry
// - set mask, privilege, bank flags on entry
// - reset class, multi-hit included, clears fpu disable flag
// - write event code and branch to vector on the same edge
// - return reloads pc and status word
// - return never restores the stack register
// - reset class goes to fixed vector
// - others go to base plus offset, debug user break to debug base
// - exception code register, hardware and software written
// - interrupt code register, hardware and software written
// - trap loads its immediate into call code
// - exception code resets by reset kind
// - event registers also answer at alias region
// - translation multi-hit aborts to reset vector
// - instruction fetch faults codes and offsets
// - illegal and fpu disabled at order four
// - data address error read/write codes
// - data miss and protection codes
// - fpu exception and initial page write
// - trap raises general exception code 160
// - user breaks code 1e0, orders 0 and 10
`timescale 1ns/1ps
`include "ceu_cfg.svh"

module ceu_top
    import ceu_pkg::*;
#(
    parameter int INT_W = 14
) (
    input wire logic clk_i, // core clock
    input wire logic rst_b_i, // async reset, active low
    input wire logic por_req_i, // power-on reset entry request
    input wire logic dbg_rst_req_i, // debug-port reset request
    input wire logic man_rst_req_i, // manual reset request
    input wire logic itlb_mhit_i, // instruction multiple hit
    input wire logic dtlb_mhit_i, // data multiple hit
    input wire logic ubrk_pre_i, // user break before instruction
    input wire logic ubrk_post_i, // user break after instruction
    input wire logic ubrk_dbg_i, // user break goes to debug base
    input wire logic iaddr_err_i, // instruction address error
    input wire logic itlb_miss_i, // instruction translation miss
    input wire logic iprot_i, // instruction protection violation
    input wire logic ill_i, // illegal instruction
    input wire logic ill_slot_i, // illegal in delay slot
    input wire logic fpud_i, // fpu disabled
    input wire logic fpud_slot_i, // fpu disabled in delay slot
    input wire logic trap_i, // unconditional trap executes
    input wire logic [7:0] trap_imm_i, // trap immediate
    input wire logic daddr_err_i, // data address error
    input wire logic dtlb_miss_i, // data translation miss
    input wire logic dprot_i, // data protection violation
    input wire logic d_write_i, // data fault was a write
    input wire logic fpu_exc_i, // fpu exception
    input wire logic ipw_i, // initial page write
    input wire logic int_req_i, // accepted interrupt request
    input wire logic [INT_W-1:0] int_code_i, // interrupt code
    input wire logic [31:0] int_ofs_i, // interrupt vector offset
    input wire logic rte_i, // return from exception executes
    input wire logic [31:0] pc_i, // current program counter
    input wire logic [31:0] sr_i, // current status word
    input wire logic [31:0] r15_i, // current stack register
    input wire logic [31:0] vector_base_i, // vector base register
    input wire logic [31:0] debug_vector_base_i, // debug vector base
    input wire logic [31:0] addr_i, // register access address
    input wire logic rd_i, // register read strobe
    input wire logic wr_i, // register write strobe
    input wire logic [31:0] wdata_i, // register write data
    output logic [31:0] rdata_o, // register read data
    output logic hit_o, // register address hit
    output logic [31:0] saved_program_counter_o, // saved pc
    output logic [31:0] saved_status_o, // saved status word
    output logic [31:0] saved_stack_copy_o, // saved stack register
    output logic [31:0] status_word_o, // new status word
    output logic status_ld_o, // status word load pulse
    output logic [31:0] pc_o, // branch target
    output logic pc_ld_o, // branch pulse
    output logic busy_o // entry or return in progress
);
    ceu_state_type state;
    ceu_state_type next_state;
    logic take_any;
    logic is_reset;
    logic is_int;
    logic is_man;
    logic [11:0] sel_code;
    ceu_vec_type sel_vec;
    logic [31:0] sel_ofs;
    logic [11:0] cur_code;
    logic cur_reset;
    logic cur_int;
    logic cur_man;
    logic [INT_W-1:0] cur_int_code;
    ceu_vec_type cur_vec;
    logic [31:0] cur_ofs;
    logic [31:0] next_sr;
    logic exp_ld;
    logic int_ld;
    logic rst_ld;

    // priority select: level 1 resets, level 2 general, then interrupts
    always_comb
    begin
        take_any = 1'b1;
        is_reset = 1'b0;
        is_int = 1'b0;
        is_man = 1'b0;
        sel_code = 12'h000;
        sel_vec = CEU_VEC_BASE;
        sel_ofs = `CEU_OFS_GEN;
        if (por_req_i || dbg_rst_req_i)
        begin
            is_reset = 1'b1;
            sel_code = `CEU_C_POR;
            sel_vec = CEU_VEC_RESET;
        end
        else if (man_rst_req_i)
        begin
            is_reset = 1'b1;
            is_man = 1'b1;
            sel_code = `CEU_C_MAN;
            sel_vec = CEU_VEC_RESET;
        end
        else if (itlb_mhit_i || dtlb_mhit_i)
        begin
            is_reset = 1'b1;
            sel_code = `CEU_C_MHIT;
            sel_vec = CEU_VEC_RESET;
        end
        else if (ubrk_pre_i)
        begin
            sel_code = `CEU_C_UBRK;
            sel_vec = ubrk_dbg_i ? CEU_VEC_DEBUG : CEU_VEC_BASE;
        end
        else if (iaddr_err_i)
        begin
            sel_code = `CEU_C_IADE;
        end
        else if (itlb_miss_i)
        begin
            sel_code = `CEU_C_ITLBM;
            sel_ofs = `CEU_OFS_MISS;
        end
        else if (iprot_i)
        begin
            sel_code = `CEU_C_IPROT;
        end
        else if (ill_i)
        begin
            sel_code = `CEU_C_ILL;
        end
        else if (ill_slot_i)
        begin
            sel_code = `CEU_C_SILL;
        end
        else if (fpud_i)
        begin
            sel_code = `CEU_C_FPUD;
        end
        else if (fpud_slot_i)
        begin
            sel_code = `CEU_C_SFPUD;
        end
        else if (trap_i)
        begin
            sel_code = `CEU_C_TRAP;
        end
        else if (daddr_err_i)
        begin
            sel_code = d_write_i ? `CEU_C_DADW : `CEU_C_DADR;
        end
        else if (dtlb_miss_i)
        begin
            sel_code = d_write_i ? `CEU_C_DTLBW : `CEU_C_DTLBR;
            sel_ofs = `CEU_OFS_MISS;
        end
        else if (dprot_i)
        begin
            sel_code = d_write_i ? `CEU_C_DPROTW : `CEU_C_DPROTR;
        end
        else if (fpu_exc_i)
        begin
            sel_code = `CEU_C_FPU;
        end
        else if (ipw_i)
        begin
            sel_code = `CEU_C_IPW;
        end
        else if (ubrk_post_i)
        begin
            sel_code = `CEU_C_UBRK;
            sel_vec = ubrk_dbg_i ? CEU_VEC_DEBUG : CEU_VEC_BASE;
        end
        else if (int_req_i)
        begin
            is_int = 1'b1;
            sel_ofs = int_ofs_i;
        end
        else
        begin
            take_any = 1'b0;
        end
    end

    // state sequencing: entry and return each take one cycle
    always_comb
    begin
        next_state = state;
        case (state)
            CEU_IDLE:
            begin
                if (take_any)
                begin
                    next_state = CEU_ENTRY;
                end
                else if (rte_i)
                begin
                    next_state = CEU_RETURN;
                end
            end
            CEU_ENTRY:
            begin
                next_state = CEU_IDLE;
            end
            CEU_RETURN:
            begin
                next_state = CEU_IDLE;
            end
            default:
            begin
                next_state = CEU_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            state <= CEU_IDLE;
        end
        else
        begin
            state <= next_state;
        end
    end

    // latch the accepted event and save context
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            cur_code <= 12'h000;
            cur_reset <= 1'b0;
            cur_int <= 1'b0;
            cur_man <= 1'b0;
            cur_int_code <= '0;
            cur_vec <= CEU_VEC_RESET;
            cur_ofs <= 32'h00000000;
            saved_program_counter_o <= 32'h00000000;
            saved_status_o <= 32'h00000000;
            saved_stack_copy_o <= 32'h00000000;
        end
        else if (state == CEU_IDLE && take_any)
        begin
            cur_code <= sel_code;
            cur_reset <= is_reset;
            cur_int <= is_int;
            cur_man <= is_man;
            cur_int_code <= int_code_i;
            cur_vec <= sel_vec;
            cur_ofs <= sel_ofs;
            saved_program_counter_o <= pc_i;
            saved_status_o <= sr_i;
            saved_stack_copy_o <= r15_i;
        end
    end

    // new status word for entry
    always_comb
    begin
        next_sr = saved_status_o;
        next_sr[`CEU_SR_BL] = 1'b1;
        next_sr[`CEU_SR_MD] = 1'b1;
        next_sr[`CEU_SR_RB] = 1'b1;
        if (cur_reset)
        begin
            next_sr[`CEU_SR_FD] = 1'b0;
        end
    end

    // status, branch and busy outputs
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            status_word_o <= 32'h00000000;
            status_ld_o <= 1'b0;
            pc_o <= 32'h00000000;
            pc_ld_o <= 1'b0;
            busy_o <= 1'b0;
        end
        else
        begin
            status_ld_o <= 1'b0;
            pc_ld_o <= 1'b0;
            busy_o <= (next_state != CEU_IDLE);
            if (state == CEU_ENTRY)
            begin
                // status and code land with the branch pulse
                status_word_o <= next_sr;
                status_ld_o <= 1'b1;
                pc_ld_o <= 1'b1;
                if (cur_vec == CEU_VEC_RESET)
                begin
                    pc_o <= `CEU_RESET_VEC;
                end
                else if (cur_vec == CEU_VEC_DEBUG)
                begin
                    pc_o <= debug_vector_base_i;
                end
                else
                begin
                    pc_o <= vector_base_i + cur_ofs;
                end
            end
            else if (state == CEU_RETURN)
            begin
                // stack register is left alone
                status_word_o <= saved_status_o;
                status_ld_o <= 1'b1;
                pc_o <= saved_program_counter_o;
                pc_ld_o <= 1'b1;
            end
        end
    end

    // event register loads during entry
    assign exp_ld = (state == CEU_ENTRY) && !cur_int;
    assign int_ld = (state == CEU_ENTRY) && cur_int;
    assign rst_ld = exp_ld && cur_reset;

    ceu_event_regs #(
        .INT_W(INT_W)
    ) u_regs (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .man_rst_i(cur_man),
        .addr_i(addr_i),
        .rd_i(rd_i),
        .wr_i(wr_i),
        .wdata_i(wdata_i),
        .exp_ld_i(exp_ld),
        .exp_code_i(cur_code),
        .int_ld_i(int_ld),
        .int_code_i(cur_int_code),
        .trap_ld_i(state == CEU_IDLE && take_any && trap_i && sel_code == `CEU_C_TRAP),
        .trap_imm_i(trap_imm_i),
        .rst_ld_i(rst_ld),
        .rdata_o(rdata_o),
        .hit_o(hit_o)
    );
endmodule

// >>> testbench/ceu_pipe_model.sv
`timescale 1ns/1ps

// pipeline side: raises fault lines and follows branches
module ceu_pipe_model (
    input wire logic clk_i, // core clock
    input wire logic rst_b_i, // async reset, active low
    input wire logic [21:0] cmd_i, // lines to raise next cycle
    input wire logic br_i, // branch pulse
    input wire logic [31:0] br_pc_i, // branch target
    input wire logic [31:0] br_sr_i, // new status word
    output logic [21:0] req_o, // fault, interrupt, return lines
    output logic [31:0] pc_o, // program counter
    output logic [31:0] sr_o, // status word
    output logic [31:0] r15_o // stack register
);
    // request lines launched just after the edge
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            req_o <= 22'h0;
        else
            req_o <= cmd_i;
    end

    // context follows each branch; handler moves the stack
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            pc_o <= 32'h8c001000;
            sr_o <= 32'h00008000;
            r15_o <= 32'h8c00fff0;
        end
        else if (br_i)
        begin
            pc_o <= br_pc_i;
            sr_o <= br_sr_i;
            r15_o <= r15_o - 32'h4;
        end
    end
endmodule

// >>> testbench/ceu_top_assertions.sv
`timescale 1ns/1ps

// entry and return timing seen at the unit's ports
module ceu_top_assertions (
    input wire logic clk_i, // core clock
    input wire logic rst_b_i, // async reset, active low
    input wire logic por_req_i, // power-on request
    input wire logic dbg_rst_req_i, // debug reset request
    input wire logic man_rst_req_i, // manual reset request
    input wire logic itlb_mhit_i, // instruction multi-hit
    input wire logic dtlb_mhit_i, // data multi-hit
    input wire logic trap_i, // trap request
    input wire logic rte_i, // return request
    input wire logic [31:0] pc_i, // program counter
    input wire logic [31:0] sr_i, // status word
    input wire logic [31:0] r15_i, // stack register
    input wire logic [31:0] vector_base_i, // vector base
    input wire logic [31:0] saved_program_counter_o, // saved pc
    input wire logic [31:0] saved_status_o, // saved status
    input wire logic [31:0] saved_stack_copy_o, // saved stack
    input wire logic [31:0] status_word_o, // new status word
    input wire logic status_ld_o, // status load pulse
    input wire logic [31:0] pc_o, // branch target
    input wire logic pc_ld_o, // branch pulse
    input wire logic busy_o // unit busy
);
    logic rst_any;
    logic gen;

    // reset request and trap-without-reset-or-multi-hit qualifiers
    assign rst_any = por_req_i | dbg_rst_req_i | man_rst_req_i;
    assign gen = trap_i & ~rst_any & ~itlb_mhit_i & ~dtlb_mhit_i;

    default clocking dcb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);

    chk_save_copies: assert property (
        $rose(busy_o) && !$past(rte_i) |-> saved_program_counter_o == $past(pc_i)
        && saved_status_o == $past(sr_i) && saved_stack_copy_o == $past(r15_i))
        else $error("saved copies wrong");
    chk_entry_flags: assert property (
        $rose(busy_o) && !$past(rte_i) |=> status_ld_o && status_word_o[30:28] == 3'h7)
        else $error("entry flags not set");
    chk_fd_clear: assert property (
        $rose(busy_o) && $past(rst_any) |=> status_word_o[15] == 1'b0)
        else $error("fd not cleared");
    chk_fd_keep: assert property (
        $rose(busy_o) && $past(gen) |=> status_word_o[15] == $past(sr_i[15], 2))
        else $error("fd changed");
    chk_reset_vec: assert property (
        $rose(busy_o) && $past(rst_any | itlb_mhit_i | dtlb_mhit_i)
        |=> pc_ld_o && pc_o == 32'ha0000000)
        else $error("reset target wrong");
    chk_trap_vec: assert property (
        $rose(busy_o) && $past(gen) |=> pc_o == $past(vector_base_i, 2) + 32'h100)
        else $error("trap target wrong");
    chk_rte_restore: assert property (
        $rose(busy_o) && $past(rte_i & ~trap_i & ~rst_any) |=> pc_ld_o
        && pc_o == saved_program_counter_o && status_word_o == saved_status_o)
        else $error("return restore wrong");
    chk_rte_stack: assert property (
        $rose(busy_o) && $past(rte_i & ~trap_i & ~rst_any)
        |-> $stable(saved_stack_copy_o) [*2])
        else $error("stack copy moved on return");
    chk_pulse_pair: assert property (
        pc_ld_o |-> status_ld_o ##1 !pc_ld_o)
        else $error("pulses disagree");
    chk_busy_span: assert property (
        $rose(busy_o) |-> ##[1:3] !busy_o)
        else $error("busy too long");

    // main scenarios
    cover property ($rose(busy_o) && $past(gen));
    cover property ($rose(busy_o) && $past(rte_i));
    cover property ($rose(busy_o) && $past(por_req_i));
endmodule

bind ceu_top ceu_top_assertions chk_u (.*);

// >>> testbench/ceu_top_tb.sv
`timescale 1ns/1ps

module ceu_top_tb;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [21:0] cmd = 22'h0;
    logic [21:0] req;
    logic ubrk_dbg_i = 1'b0;
    logic [7:0] trap_imm_i = 8'h0;
    logic d_write_i = 1'b0;
    logic [13:0] int_code_i = 14'h0;
    logic [31:0] int_ofs_i = 32'h600;
    logic [31:0] vector_base_i = 32'h0;
    logic [31:0] debug_vector_base_i = 32'h0;
    logic [31:0] addr_i = 32'h0;
    logic rd_i = 1'b0;
    logic wr_i = 1'b0;
    logic [31:0] wdata_i = 32'h0;
    logic [31:0] rdata_o, pc_i, sr_i, r15_i, pc_o, status_word_o;
    logic [31:0] saved_program_counter_o, saved_status_o, saved_stack_copy_o;
    logic hit_o, status_ld_o, pc_ld_o, busy_o;
    logic [31:0] seed = 32'h9876;
    logic [31:0] v, tgt, ra, rx, et, es, em;
    logic [32:0] er;
    logic [31:0] br_q[$];
    logic [32:0] rd_q[$];
    logic rd_d = 1'b0;
    int fail_count = 0;
    int comparisons = 0;
    int bn[24] = '{0, 1, 2, 3, 4, 5, 7, 8, 9, 10, 11, 12, 13, 14, 15, 47, 16, 48, 17, 49,
                   18, 19, 6, 20};
    logic [11:0] cd[24] = '{12'h000, 12'h000, 12'h020, 12'h140, 12'h140, 12'h1e0,
                            12'h0e0, 12'h040, 12'h0a0, 12'h180, 12'h1a0, 12'h800,
                            12'h820, 12'h160, 12'h0e0, 12'h100, 12'h040, 12'h060,
                            12'h0a0, 12'h0c0, 12'h120, 12'h080, 12'h1e0, 12'h000};

    ceu_top #(.INT_W(14)) dut_u (
        .clk_i, .rst_b_i, .por_req_i(req[0]), .dbg_rst_req_i(req[1]),
        .man_rst_req_i(req[2]), .itlb_mhit_i(req[3]), .dtlb_mhit_i(req[4]),
        .ubrk_pre_i(req[5]), .ubrk_post_i(req[6]), .ubrk_dbg_i, .iaddr_err_i(req[7]),
        .itlb_miss_i(req[8]), .iprot_i(req[9]), .ill_i(req[10]), .ill_slot_i(req[11]),
        .fpud_i(req[12]), .fpud_slot_i(req[13]), .trap_i(req[14]), .trap_imm_i,
        .daddr_err_i(req[15]), .dtlb_miss_i(req[16]), .dprot_i(req[17]), .d_write_i,
        .fpu_exc_i(req[18]), .ipw_i(req[19]), .int_req_i(req[20]), .int_code_i,
        .int_ofs_i, .rte_i(req[21]), .pc_i, .sr_i, .r15_i, .vector_base_i,
        .debug_vector_base_i, .addr_i, .rd_i, .wr_i, .wdata_i, .rdata_o, .hit_o,
        .saved_program_counter_o, .saved_status_o, .saved_stack_copy_o,
        .status_word_o, .status_ld_o, .pc_o, .pc_ld_o, .busy_o
    );

    ceu_pipe_model pipe_u (
        .clk_i, .rst_b_i, .cmd_i(cmd), .br_i(pc_ld_o), .br_pc_i(pc_o),
        .br_sr_i(status_word_o), .req_o(req), .pc_o(pc_i), .sr_o(sr_i), .r15_o(r15_i)
    );

    // 100 MHz core clock
    initial
    begin
        forever #5 clk_i = ~clk_i;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic cmp(input string n, input logic [31:0] x, input logic [31:0] g);
        comparisons++;
        if (g !== x)
        begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", n, x, g);
        end
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic wr_reg(input logic [31:0] a, input logic [31:0] d, input logic w = 1'b1);
        @(posedge clk_i);
        #1 addr_i = a;
        wdata_i = d;
        {wr_i, rd_i} = {w, !w};
        @(posedge clk_i);
        #1 {wr_i, rd_i} = 2'b00;
    endtask

    task automatic rd_reg(input logic [31:0] a, input logic [31:0] x, input logic h);
        rd_q.push_back({h, x});
        wr_reg(a, 32'h0, 1'b0);
    endtask

    // pulse a command, wait for branch
    task automatic issue(input logic [21:0] m);
        @(posedge clk_i);
        #1 cmd = m;
        @(posedge clk_i);
        #1 cmd = 22'h0;
        for (int i = 0; i < 20 && br_q.size() > 0; i++)
            @(posedge clk_i);
        repeat (2) @(posedge clk_i);
        #1;
    endtask

    // entry, event register read, then return to the old context
    task automatic entry(input logic [21:0] m, input logic clr, input logic dc);
        logic [31:0] pc0, sr0;
        pc0 = pc_i;
        sr0 = sr_i;
        br_q.push_back(tgt);
        br_q.push_back((sr0 | 32'h70000000) & ~{16'h0, clr, 15'h0});
        br_q.push_back(dc ? 32'hffff7fff : 32'hffffffff);
        issue(m);
        rd_reg(ra, rx, 1'b1);
        br_q.push_back(pc0);
        br_q.push_back(sr0);
        br_q.push_back(32'hffffffff);
        issue(22'h200000);
    endtask

    // compares each branch and each read with the oldest note
    always @(posedge clk_i)
    begin
        if (pc_ld_o === 1'b1)
        begin
            et = br_q.pop_front();
            es = br_q.pop_front();
            em = br_q.pop_front();
            cmp("branch target", et, pc_o);
            cmp("status word", es & em, status_word_o & em);
        end
        if (rd_d)
        begin
            er = rd_q.pop_front();
            cmp("register hit", {31'h0, er[32]}, {31'h0, hit_o});
            if (er[32])
                cmp("read data", er[31:0], rdata_o);
        end
        rd_d <= rd_i;
    end

    // few hundred cycles needed
    initial
    begin
        #200000;
        fail_count++;
        print_verdict();
    end

    initial
    begin
        repeat (5) @(posedge clk_i);
        #1 rst_b_i = 1'b1;
        rd_reg(32'hff000024, 32'h0, 1'b1);
        rd_reg(32'hff000030, 32'h0, 1'b0);
        v = rnd();
        wr_reg(32'hff000024, {20'h0, v[11:0]});
        rd_reg(32'h1f000024, {20'h0, v[11:0]}, 1'b1);
        wr_reg(32'h7f000028, {18'h0, v[25:12]});
        rd_reg(32'hff000028, {18'h0, v[25:12]}, 1'b1);
        wr_reg(32'hff000020, {22'h0, v[7:0], 2'h0});
        rd_reg(32'hbf000020, {22'h0, v[7:0], 2'h0}, 1'b1);
        for (int k = 0; k < 24; k++)
        begin
            v = rnd();
            vector_base_i = {v[31:12], 12'h0};
            trap_imm_i = v[7:0];
            int_code_i = v[13:0];
            d_write_i = bn[k] > 31;
            tgt = vector_base_i + ((cd[k] == 12'h040 || cd[k] == 12'h060) ? 32'h400 : 32'h100);
            tgt = k < 5 ? 32'ha0000000 : (k == 23 ? vector_base_i + int_ofs_i : tgt);
            ra = k == 23 ? 32'hff000028 : 32'hff000024;
            rx = k == 23 ? {18'h0, int_code_i} : {20'h0, cd[k]};
            entry(22'h1 << (bn[k] % 32), k < 3, k == 3 || k == 4);
            if (k == 13)
                rd_reg(32'hff000020, {22'h0, trap_imm_i, 2'h0}, 1'b1);
        end
        ubrk_dbg_i = 1'b1;
        debug_vector_base_i = rnd();
        tgt = debug_vector_base_i;
        ra = 32'hff000024;
        rx = 32'h1e0;
        entry(22'h20, 1'b0, 1'b0);
        ubrk_dbg_i = 1'b0;
        tgt = 32'ha0000000;
        rx = 32'h0;
        entry(22'h4001, 1'b1, 1'b0);
        rx = 32'h20;
        entry(22'hc, 1'b1, 1'b0);
        tgt = vector_base_i + 32'h100;
        rx = 32'he0;
        entry(22'h14080, 1'b0, 1'b0);
        #1 rst_b_i = 1'b0;
        @(posedge clk_i);
        #1 rst_b_i = 1'b1;
        rd_reg(32'hff000024, 32'h0, 1'b1);
        @(posedge clk_i);
        #1 cmp("notes left", 32'h0, 32'(br_q.size() + rd_q.size()));
        print_verdict();
    end
endmodule
